/* src/adc_cfg_pkg.sv */
// Contract
// RQ1: Reset pin held high selects parallel control
// RQ2: Parallel mode configures itself from pin levels
// RQ3: Parallel mode: enable/clock pins are level straps
// RQ4: Parallel mode: serial data ignored, held low
// RQ5: Reset pin low: three pins form serial port
// RQ6: Controller resets registers before serial use
// RQ7: Controller keeps reset pin low afterwards
// RQ8: Serial-only: mode pins tied to ground
// RQ9: Combined mode: mode pins stay active
// RQ10: Override zero: mode pins choose power modes
// RQ11: Override one: register bits choose power modes
// RQ12: Clock strap selects coarse gain and reference
// RQ13: Enable strap selects output format and interface
// RQ14: Three mode pins select power and mux modes
// RQ15: Results appear ten sample clocks after sampling
// RQ16: Low output supply: capture with delayed clock; the bench captures conv_out on ref_clk, with no delayed clock
// RQ17: Mode pin code table, eight modes
// RQ18: Soft reset restores defaults, then self-clears
// RQ19: Straps arrive as two-bit codes, decoded combinationally
`default_nettype none
package adc_cfg_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LATENCY_CYC   = 10;
  localparam int RST_PULSE_NS  = 10;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS  = 25;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Serial word and device registers
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam logic [7:0] ADR_RESET  = 8'h00;
  localparam logic [7:0] ADR_POWER  = 8'h01;
  localparam logic [7:0] ADR_FORMAT = 8'h02;
  localparam int RST_BIT    = 0;
  localparam int PIN_OVERRIDE_BIT_BIT   = 0;
  localparam int PD_LSB     = 1;
  localparam int GAIN_BIT   = 0;
  localparam int EXTREF_BIT = 1;
  localparam int BIN_BIT    = 2;
  localparam int CMOS_BIT   = 3;
  localparam logic [7:0] POWER_RST  = 8'h00;
  localparam logic [7:0] FORMAT_RST = 8'h00;

  // ----------------------------------------
  // Controller APB registers
  // ----------------------------------------
  localparam logic [7:0] HOST_CTRL   = 8'h00;
  localparam logic [7:0] HOST_PINS   = 8'h04;
  localparam logic [7:0] HOST_WORD   = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0C;
  localparam int CTRL_PAR_BIT   = 0;
  localparam int CTRL_HWRST_BIT = 1;
  localparam int CTRL_SONLY_BIT = 2;
  localparam int PINS_SCLK_LSB  = 0;
  localparam int PINS_SEN_LSB   = 2;
  localparam int PINS_MODE_LSB  = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [6:0] PINS_RST = 7'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LVL_ZERO = 2'h0,
    LVL_3_8  = 2'h1,
    LVL_5_8  = 2'h2,
    LVL_FULL = 2'h3
  } strap_lvl_t;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_A_OFF  = 3'h1,
    MODE_B_OFF  = 3'h2,
    MODE_AB_OFF = 3'h3,
    MODE_PD     = 3'h4,
    MODE_A_STBY = 3'h5,
    MODE_B_STBY = 3'h6,
    MODE_MUX    = 3'h7
  } mode_code_t;

  typedef struct packed {
    logic gain_35db;
    logic ext_ref;
    logic straight_bin;
    logic cmos_out;
  } cfg_t;

endpackage
`default_nettype wire

/* src/adc_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adc_cfg_if;
  logic       reset_pin;          // High: parallel control or reset pulse
  logic       serial_select_n;    // Serial enable, digital use
  logic       serial_clock;       // Serial clock, digital use
  logic       serial_input_data;  // Serial data
  logic [1:0] sen_level;          // Enable pin as comparator level code
  logic [1:0] sclk_level;         // Clock pin as comparator level code
  logic       mode_pin_one;       // Mode pin, code MSB
  logic       mode_pin_two;       // Mode pin, middle
  logic       mode_pin_three;     // Mode pin, code LSB

  modport dev (
    input reset_pin, serial_select_n, serial_clock, serial_input_data,
    input sen_level, sclk_level, mode_pin_one, mode_pin_two, mode_pin_three
  );
  modport ctl (
    output reset_pin, serial_select_n, serial_clock, serial_input_data,
    output sen_level, sclk_level, mode_pin_one, mode_pin_two, mode_pin_three
  );
endinterface
`default_nettype wire

/* src/strap_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module strap_decode
  import adc_cfg_pkg::*;
(
  input  wire logic [1:0] sclk_level,  // Clock strap level code
  input  wire logic [1:0] sen_level,   // Enable strap level code
  output var cfg_t        cfg          // Decoded settings
);

  // Straps decoded with no state; the selector downstream registers them
  always_comb begin
    cfg = '0;
    unique case (strap_lvl_t'(sclk_level))  // RQ19
      LVL_ZERO: begin cfg.gain_35db = 1'b0; cfg.ext_ref = 1'b0; end  // RQ12
      LVL_3_8:  begin cfg.gain_35db = 1'b0; cfg.ext_ref = 1'b1; end  // RQ12
      LVL_5_8:  begin cfg.gain_35db = 1'b1; cfg.ext_ref = 1'b1; end  // RQ12
      LVL_FULL: begin cfg.gain_35db = 1'b1; cfg.ext_ref = 1'b0; end  // RQ12
    endcase
    unique case (strap_lvl_t'(sen_level))  // RQ19
      LVL_ZERO: begin cfg.straight_bin = 1'b0; cfg.cmos_out = 1'b0; end  // RQ13
      LVL_3_8:  begin cfg.straight_bin = 1'b1; cfg.cmos_out = 1'b0; end  // RQ13
      LVL_5_8:  begin cfg.straight_bin = 1'b1; cfg.cmos_out = 1'b1; end  // RQ13
      LVL_FULL: begin cfg.straight_bin = 1'b0; cfg.cmos_out = 1'b1; end  // RQ13
    endcase
  end

endmodule
`default_nettype wire

/* src/adc_cfg_dev.sv */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_dev
  import adc_cfg_pkg::*;
#(
  parameter int DATA_W  = 14,           // Sample width
  parameter int LATENCY = LATENCY_CYC   // Sample clocks to output
) (
  input  wire logic              ref_clk,       // Sample clock
  input  wire logic              nrst,          // Power-up reset, active low
  adc_cfg_if.dev                 link,          // Pins from controller
  input  wire logic [DATA_W-1:0] conv_in,       // Raw conversion result
  output logic      [DATA_W-1:0] conv_out,      // Delayed result
  output logic                   parallel_mode, // Pins control the device
  output logic                   gain_35db,     // Coarse gain 3.5 dB
  output logic                   ext_ref,       // External reference
  output logic                   straight_bin,  // Straight binary, else 2s
  output logic                   cmos_out,      // CMOS, else DDR LVDS
  output logic                   cha_out_off,   // Channel A buffer off
  output logic                   chb_out_off,   // Channel B buffer off
  output logic                   global_pd,     // Global power-down
  output logic                   cha_standby,   // Channel A standby
  output logic                   chb_standby,   // Channel B standby
  output logic                   mux_mode       // Multiplexed CMOS output
);

  // ----------------------------------------
  // Configuration source
  // ----------------------------------------

  // Level of the reset pin picks pins or registers
  logic par_mode;
  assign par_mode = link.reset_pin;  // RQ1

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------

  logic              sclk_prev_q;
  logic [14:0]       shift_q;
  logic [3:0]        bit_cnt_q;
  logic              sclk_fall;
  logic              word_done;
  logic [WORD_W-1:0] word;

  // Port only listens with reset pin low; data pin is dead otherwise
  assign sclk_fall = sclk_prev_q & ~link.serial_clock
                   & ~link.serial_select_n & ~par_mode;  // RQ5 RQ4
  assign word      = {shift_q, link.serial_input_data};
  assign word_done = sclk_fall & (bit_cnt_q == 4'hF);

  // Clock history for falling-edge detect
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= link.serial_clock;
    end
  end

  // Bits latched on each falling clock edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      shift_q <= '0;
    end else if (sclk_fall) begin
      shift_q <= word[14:0];  // RQ5
    end
  end

  // Enable high drops a partial word; the count wraps, so each further 16 bits in a frame form another word
  always_ff @(posedge ref_clk) begin
    if (!nrst || link.serial_select_n || par_mode) begin
      bit_cnt_q <= 4'h0;
    end else if (sclk_fall) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  logic [7:0] power_q;
  logic [7:0] format_q;
  logic       soft_rst_q;
  logic       regs_dflt;
  logic       wr_power;
  logic       wr_format;
  logic       wr_reset;

  // Pin pulse and soft reset both force defaults
  assign regs_dflt = par_mode | soft_rst_q;  // RQ18
  assign wr_power  = word_done & (word[15:8] == ADR_POWER);
  assign wr_format = word_done & (word[15:8] == ADR_FORMAT);
  assign wr_reset  = word_done & (word[15:8] == ADR_RESET);

  // Self-clearing soft reset, one cycle wide
  always_ff @(posedge ref_clk) begin
    if (!nrst || par_mode) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_reset & word[RST_BIT];  // RQ18
    end
  end

  // Override and power-down code
  always_ff @(posedge ref_clk) begin
    if (!nrst || regs_dflt) begin
      power_q <= POWER_RST;  // RQ18
    end else if (wr_power) begin
      power_q <= word[7:0];
    end
  end

  // Gain, reference and output format
  always_ff @(posedge ref_clk) begin
    if (!nrst || regs_dflt) begin
      format_q <= FORMAT_RST;  // RQ18
    end else if (wr_format) begin
      format_q <= word[7:0];
    end
  end

  // ----------------------------------------
  // Setting selection
  // ----------------------------------------

  cfg_t       strap_cfg;
  cfg_t       reg_cfg;
  cfg_t       cfg_sel;
  mode_code_t pin_code;
  mode_code_t reg_code;
  mode_code_t mode_sel;
  logic       pin_override_bit;

  strap_decode u_strap (
    .sclk_level (link.sclk_level),
    .sen_level  (link.sen_level),
    .cfg        (strap_cfg)
  );

  // Register image of the strap settings
  always_comb begin
    reg_cfg              = '0;
    reg_cfg.gain_35db    = format_q[GAIN_BIT];
    reg_cfg.ext_ref      = format_q[EXTREF_BIT];
    reg_cfg.straight_bin = format_q[BIN_BIT];
    reg_cfg.cmos_out     = format_q[CMOS_BIT];
  end

  // Straps only count in parallel mode
  assign cfg_sel = par_mode ? strap_cfg : reg_cfg;  // RQ2 RQ3

  // Mode pins are live in every mode; override reachable only serially
  assign pin_code = mode_code_t'({link.mode_pin_one, link.mode_pin_two,
                                  link.mode_pin_three});  // RQ14 RQ9
  assign reg_code = mode_code_t'(power_q[PD_LSB +: 3]);
  assign pin_override_bit     = ~par_mode & power_q[PIN_OVERRIDE_BIT_BIT];
  assign mode_sel = pin_override_bit ? reg_code : pin_code;  // RQ10 RQ11

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------

  logic [5:0] pwr_d;  // a_off, b_off, pd, a_stby, b_stby, mux

  // Power flags from the mode code; one flag per code, except none for MODE_NORMAL and two for MODE_AB_OFF
  always_comb begin
    pwr_d = 6'h00;
    unique case (mode_sel)  // RQ17
      MODE_NORMAL: pwr_d = 6'h00;
      MODE_A_OFF:  pwr_d = 6'h20;
      MODE_B_OFF:  pwr_d = 6'h10;
      MODE_AB_OFF: pwr_d = 6'h30;
      MODE_PD:     pwr_d = 6'h08;
      MODE_A_STBY: pwr_d = 6'h04;
      MODE_B_STBY: pwr_d = 6'h02;
      MODE_MUX:    pwr_d = 6'h01;
    endcase
  end

  // Registered so that pin glitches give one clean update per cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      parallel_mode <= 1'b0;
      gain_35db     <= 1'b0;
      ext_ref       <= 1'b0;
      straight_bin  <= 1'b0;
      cmos_out      <= 1'b0;
    end else begin
      parallel_mode <= par_mode;  // RQ1
      gain_35db     <= cfg_sel.gain_35db;  // RQ2
      ext_ref       <= cfg_sel.ext_ref;
      straight_bin  <= cfg_sel.straight_bin;
      cmos_out      <= cfg_sel.cmos_out;
    end
  end

  // Power flags; mux only exists on the CMOS interface
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cha_out_off <= 1'b0;
      chb_out_off <= 1'b0;
      global_pd   <= 1'b0;
      cha_standby <= 1'b0;
      chb_standby <= 1'b0;
      mux_mode    <= 1'b0;
    end else begin
      cha_out_off <= pwr_d[5];  // RQ14
      chb_out_off <= pwr_d[4];
      global_pd   <= pwr_d[3];
      cha_standby <= pwr_d[2];
      chb_standby <= pwr_d[1];
      mux_mode    <= pwr_d[0] & cfg_sel.cmos_out;
    end
  end

  // ----------------------------------------
  // Low-latency data path
  // ----------------------------------------

  logic [DATA_W-1:0] pipe_q [LATENCY];

  // Fixed delay line; costs LATENCY words of flops
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      pipe_q[0] <= conv_in;  // RQ15
      for (int i = 1; i < LATENCY; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign conv_out = pipe_q[LATENCY-1];  // RQ15

endmodule
`default_nettype wire

/* src/adc_cfg_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_ctl
  import adc_cfg_pkg::*;
(
  input  wire logic        ref_clk,  // System clock
  input  wire logic        nrst,     // Reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped address
  adc_cfg_if.ctl           link      // Pins to the converter
);

  typedef enum {H_IDLE, H_RST, H_GAP, H_SETUP, H_HIGH, H_LOW, H_HOLD} hstate_t;

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == HOST_CTRL) || (a == HOST_PINS) ||
           (a == HOST_WORD) || (a == HOST_STATUS);
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------

  logic              wr;
  logic [2:0]        ctrl_q;
  logic [6:0]        pins_q;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] sh_q;
  logic [31:0]       prdata_q;
  logic [3:0]        cnt_q;
  logic [3:0]        bits_q;
  logic              sen_n_q;
  logic              sclk_q;
  logic              serial_input_data_q;
  logic              busy;
  logic              go_rst;
  logic              go_word;
  hstate_t           st_q;

  assign wr      = psel & penable & pwrite & addr_ok(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign prdata  = prdata_q;
  assign busy    = (st_q != H_IDLE);
  assign go_rst  = wr & (paddr == HOST_CTRL) & pwdata[CTRL_HWRST_BIT] & ~busy;  // RQ6
  assign go_word = wr & (paddr == HOST_WORD) & ~busy & ~ctrl_q[CTRL_PAR_BIT];

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        HOST_CTRL:   prdata_q[2:0] <= ctrl_q;
        HOST_PINS:   prdata_q[6:0] <= pins_q;
        HOST_WORD:   prdata_q[WORD_W-1:0] <= word_q;
        HOST_STATUS: prdata_q[STAT_BUSY_BIT] <= busy;
        default:     prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control and strap registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      pins_q <= PINS_RST;
    end else if (wr && paddr == HOST_CTRL) begin
      ctrl_q <= pwdata[2:0] & ~3'(1 << CTRL_HWRST_BIT);
    end else if (wr && paddr == HOST_PINS) begin
      pins_q <= pwdata[6:0];
    end
  end

  // Last word queued for shifting
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      word_q <= '0;
    end else if (go_word) begin
      word_q <= pwdata[WORD_W-1:0];
    end
  end

  // ----------------------------------------
  // Pin sequencer
  // ----------------------------------------

  // Device latches on the falling clock edge, so data is set while high
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q    <= H_IDLE;
      cnt_q   <= 4'h0;
      bits_q  <= 4'h0;
      sh_q    <= '0;
      sen_n_q <= 1'b1;
      sclk_q  <= 1'b0;
      serial_input_data_q <= 1'b0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (go_rst) begin
            st_q  <= H_RST;
            cnt_q <= 4'(RST_PULSE_CYC - 1);
          end else if (go_word) begin
            st_q    <= H_SETUP;
            cnt_q   <= 4'(SCLK_HALF_CYC - 1);
            sh_q    <= pwdata[WORD_W-1:0];
            bits_q  <= 4'h0;
            sen_n_q <= 1'b0;
          end
        end
        H_RST: begin
          st_q  <= H_GAP;  // RQ7
          cnt_q <= 4'(SCLK_HALF_CYC - 1);
        end
        H_GAP: st_q <= H_IDLE;
        H_SETUP, H_LOW: begin
          if (st_q == H_LOW && bits_q == 4'hF) begin
            st_q  <= H_HOLD;
            cnt_q <= 4'(SCLK_HALF_CYC - 1);
          end else begin
            st_q    <= H_HIGH;
            cnt_q   <= 4'(SCLK_HALF_CYC - 1);
            sclk_q  <= 1'b1;
            serial_input_data_q <= sh_q[WORD_W-1];
            bits_q  <= (st_q == H_LOW) ? bits_q + 4'h1 : bits_q;
          end
        end
        H_HIGH: begin
          st_q   <= H_LOW;
          cnt_q  <= 4'(SCLK_HALF_CYC - 1);
          sclk_q <= 1'b0;
          sh_q   <= {sh_q[WORD_W-2:0], 1'b0};
        end
        H_HOLD: begin
          st_q    <= H_IDLE;
          sen_n_q <= 1'b1;
          serial_input_data_q <= 1'b0;
        end
      endcase
    end
  end

  // Reset pin: held high for parallel, else only the pulse
  assign link.reset_pin         = ctrl_q[CTRL_PAR_BIT] | (st_q == H_RST);  // RQ1 RQ6 RQ7
  assign link.serial_select_n   = sen_n_q;
  assign link.serial_clock      = sclk_q;
  assign link.serial_input_data = serial_input_data_q;  // RQ4
  assign link.sclk_level        = pins_q[PINS_SCLK_LSB +: 2];
  assign link.sen_level         = pins_q[PINS_SEN_LSB +: 2];
  // Serial-only grounds the mode pins
  assign link.mode_pin_one   = pins_q[PINS_MODE_LSB+2] & ~ctrl_q[CTRL_SONLY_BIT];  // RQ8
  assign link.mode_pin_two   = pins_q[PINS_MODE_LSB+1] & ~ctrl_q[CTRL_SONLY_BIT];  // RQ8
  assign link.mode_pin_three = pins_q[PINS_MODE_LSB]   & ~ctrl_q[CTRL_SONLY_BIT];  // RQ8

endmodule
`default_nettype wire

/* tb/adc_cfg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker (
  input wire logic ref_clk,           // Clock
  input wire logic nrst,              // Reset, active low
  input wire logic reset_pin,         // Mode or reset pin
  input wire logic serial_select_n,   // Serial enable
  input wire logic serial_clock,      // Serial clock
  input wire logic serial_input_data  // Serial data
);
  // ----------------------------------------
  // Helper: falls seen in the current frame
  // ----------------------------------------
  // A frame that ends early would drop a word silently, so count its falls
  logic [5:0] fall_q;
  logic       sclk_q;
  always_ff @(posedge ref_clk) begin
    sclk_q <= serial_clock;
    if (!nrst || serial_select_n) begin
      fall_q <= 6'h00;
    end else if (sclk_q && !serial_clock) begin
      fall_q <= fall_q + 6'h01;
    end
  end

  // ----------------------------------------
  // Wire properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_reset_idle: assert property (!$past(nrst) |-> !reset_pin && serial_select_n && !serial_clock)
    else $error("link not idle after reset");
  chk_serial_input_data_idle: assert property ((serial_select_n || reset_pin) |-> !serial_input_data)
    else $error("serial data not low while idle");
  chk_sclk_idle: assert property (serial_select_n |-> !serial_clock)
    else $error("serial clock moves outside frame");
  chk_par_quiet: assert property (reset_pin |-> serial_select_n)
    else $error("frame opened while reset pin high");
  chk_sen_setup: assert property ($fell(serial_select_n) |-> !serial_clock [*3] ##1 serial_clock)
    else $error("enable to clock setup wrong");
  chk_sclk_high: assert property ($rose(serial_clock) |-> serial_clock [*3] ##1 !serial_clock)
    else $error("clock high phase wrong");
  chk_sclk_low: assert property ($fell(serial_clock) |-> !serial_clock [*3])
    else $error("clock low phase too short");
  chk_data_hold: assert property ((serial_clock || $fell(serial_clock)) && !$rose(serial_clock)
    |-> $stable(serial_input_data))
    else $error("serial data moved around clock");
  chk_word_len: assert property ($rose(serial_select_n) |-> fall_q == 6'h10)
    else $error("frame not sixteen bits");
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import adc_cfg_pkg::*;
;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] conv_in, conv_out;
  logic        pm, g35, xr, sb, cm, aoff, boff, gpd, astb, bstb, mux;
  logic [10:0] obs;
  logic [13:0] lq[$];
  int          err_count, compares, cyc, par, so, slev, elev, code, r1, r2;

  assign obs = {pm, g35, xr, sb, cm, aoff, boff, gpd, astb, bstb, mux};

  adc_cfg_if link_if ();
  adc_cfg_ctl adc_cfg_ctl_inst (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  adc_cfg_dev adc_cfg_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link_if), .conv_in(conv_in),
    .conv_out(conv_out), .parallel_mode(pm), .gain_35db(g35), .ext_ref(xr), .straight_bin(sb),
    .cmos_out(cm), .cha_out_off(aoff), .chb_out_off(boff), .global_pd(gpd), .cha_standby(astb),
    .chb_standby(bstb), .mux_mode(mux));
  adc_cfg_checker adc_cfg_checker_inst (.ref_clk(ref_clk), .nrst(nrst), .reset_pin(link_if.reset_pin),
    .serial_select_n(link_if.serial_select_n), .serial_clock(link_if.serial_clock),
    .serial_input_data(link_if.serial_input_data));

  // ----------------------------------------
  // Clock, timeout, data path model
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Ceiling well above the longest serial traffic of the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  // Fresh sample every cycle; the queue restarts with each reset
  always @(posedge ref_clk) begin
    conv_in <= 14'($urandom);
    if (!nrst) begin
      lq.delete();
    end else begin
      lq.push_back(conv_in);
      // Captured on the bench's own clock, never on a device output clock
      if (lq.size() > 10) check("conv_out", lq.pop_front(), conv_out);
    end
  end

  // ----------------------------------------
  // Model and tasks
  // ----------------------------------------
  function automatic logic [10:0] exp_vec();
    int c;
    logic g, x, b, m;
    c = so ? 0 : code;
    if (!par && r1[0]) c = (r1 >> 1) & 7;
    g = par ? slev[1] : r2[0];
    x = par ? (slev == 1 || slev == 2) : r2[1];
    b = par ? (elev == 1 || elev == 2) : r2[2];
    m = par ? elev[1] : r2[3];
    return {par[0], g, x, b, m, c == 1 || c == 3, c == 2 || c == 3, c == 4, c == 5, c == 6, c == 7 && m};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    check(nm, x, q);
    check({nm, " pslverr"}, {31'h0, xe}, {31'h0, e});
  endtask

  task automatic idle();
    logic [31:0] q;
    logic e;
    do apb(1'b0, HOST_STATUS, 32'h00000000, q, e); while (q[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic word(input int a, input int d);
    wr(HOST_WORD, 32'((a << 8) | d));
    idle();
    if (!par && a == 1) r1 = d;
    if (!par && a == 2) r2 = d;
    if (!par && a == 0 && (d & 1)) begin
      r1 = 0;
      r2 = 0;
    end
  endtask

  task automatic pins(input int s, input int e, input int c);
    slev = s;
    elev = e;
    code = c;
    wr(HOST_PINS, 32'((c << 4) | (e << 2) | s));
  endtask

  // Reset pin high, as level or pulse, holds device registers at defaults
  task automatic ctrl(input int v);
    par = v & 1;
    so = (v >> 2) & 1;
    if (par || (v & 2)) begin
      r1 = 0;
      r2 = 0;
    end
    wr(HOST_CTRL, 32'(v));
    if (v & 2) idle();
  endtask

  task automatic cfg(input string nm);
    repeat (4) @(posedge ref_clk);
    check(nm, exp_vec(), obs);
  endtask

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    conv_in = 14'h0000;
    void'($urandom(32'h90499946));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    cfg("cfg after reset");
    wr(HOST_PINS, 32'hFFFFFFFF);
    {slev, elev, code} = {32'd3, 32'd3, 32'd7};
    rdc("pins reg", HOST_PINS, 32'h0000007F, 1'b0);
    rdc("unmapped", 8'h10, 32'h00000000, 1'b1);
    ctrl(1);
    rdc("ctrl reg", HOST_CTRL, 32'h00000001, 1'b0);
    for (int i = 0; i < 16; i++) begin
      pins(i & 3, i >> 2, i & 7);
      cfg("parallel straps");
    end
    repeat (6) begin
      pins($urandom % 4, $urandom % 4, $urandom % 8);
      cfg("parallel random");
    end
    word(2, 15);
    cfg("word in parallel");
    ctrl(2);
    cfg("after pin reset");
    word(2, 8);
    for (int c = 0; c < 8; c++) begin
      pins(3, 3, c);
      cfg("combined pins");
    end
    for (int c = 0; c < 8; c++) begin
      word(1, 1 | (c << 1));
      cfg("override regs");
    end
    word(2, $urandom % 16);
    cfg("format regs");
    word(0, 1);
    cfg("soft reset");
    word(2, 5);
    cfg("after soft reset");
    rdc("word reg", HOST_WORD, 32'h00000205, 1'b0);
    word(3, 255);
    cfg("unknown address");
    ctrl(2);
    cfg("pin reset clears");
    ctrl(4);
    pins(0, 0, 5);
    cfg("serial only");
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    {par, so, slev, elev, code, r1, r2} = '0;
    nrst <= 1'b1;
    cfg("second reset");
    finish_test();
  end
endmodule
`default_nettype wire
